// ==== common/ipc_pkg.sv ====
// Constants and types shared by the power-save sequencer
package ipc_pkg;
  localparam logic [31:0] OFS_PSC = 32'h0000_0000;
  localparam logic [31:0] OFS_OSC_SETTLE_SELECT = 32'h0000_0004;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
  localparam int PSC_IDLE_POS = 1;
  localparam int PSC_STP_POS = 0;
  localparam logic [2:0] OSC_SETTLE_SELECT_RESET = 3'h4;
  localparam logic [1:0] PSC_RESET = 2'h0;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] SETTLE_0 = 20'h04000;
  localparam logic [CNT_W-1:0] SETTLE_1 = 20'h10000;
  localparam logic [CNT_W-1:0] SETTLE_2 = 20'h20000;
  localparam logic [CNT_W-1:0] SETTLE_3 = 20'h40000;
  localparam logic [CNT_W-1:0] SETTLE_4 = 20'h80000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_IDLE = 4'h2,
    ST_STOP = 4'h4,
    ST_SETTLE = 4'h8
  } ipc_state_type;
endpackage : ipc_pkg

// ==== hw/ipc_settle_counter.sv ====
// Oscillator settling counter, reused watchdog count
`timescale 1ns/10ps
module ipc_settle_counter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] osc_settle_select,
  output logic done,
  output logic busy
);
  typedef struct packed {
    logic [ipc_pkg::CNT_W-1:0] cnt;
    logic [ipc_pkg::CNT_W-1:0] span;
    logic busy;
    logic done;
  } ipc_cnt_state_type;

  ipc_cnt_state_type st;
  ipc_cnt_state_type next_st;
  logic [ipc_pkg::CNT_W-1:0] load;

  always_comb begin
    case (osc_settle_select)
      3'h0: load = ipc_pkg::SETTLE_0; // [R19]
      3'h1: load = ipc_pkg::SETTLE_1;
      3'h2: load = ipc_pkg::SETTLE_2;
      3'h3: load = ipc_pkg::SETTLE_3;
      default: load = ipc_pkg::SETTLE_4;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.cnt = load - 20'h00001; // [R15]
      next_st.busy = 1'b1;
      next_st.span = 20'h00000;
    end else if (st.busy) begin
      next_st.span = st.span + 20'h00001;
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 20'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
  assign busy = st.busy;

  settle_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    done |-> st.span == load) // [R15]
    else $error("settle count length wrong");
endmodule : ipc_settle_counter

// ==== hw/ipc_clock_gate.sv ====
// Glitch-free clock gate, latch-free: enable caught on falling edge
`timescale 1ns/10ps
module ipc_clock_gate (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  output logic gclk
);
  logic en_q;

  // Enable changes only while clk is low, so gclk never slivers
  always_ff @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable; // [R20]
    end
  end

  assign gclk = clk & en_q;
endmodule : ipc_clock_gate

// ==== hw/ipc_power_save.sv ====
// Idle/stop power-save sequencer with AHB-Lite registers
// Functional notes
// [R1] Writing idle bit enters light mode
// [R2] Light mode gates main clock, oscillator runs
// [R3] Sub clock keeps running in light mode
// [R4] Light mode wake resumes with no wait
// [R5] Light mode halts CPU, holds state
// [R6] Light mode stops main-clocked peripherals
// [R7] Bus hold requests ignored in light mode
// [R8] NMI, unmasked interrupt or reset wake light
// [R9] Writing stop bit enters deep stop
// [R10] Deep stop halts main oscillator
// [R11] Software requests stop only on main clock
// [R12] Deep stop halts CPU, holds state
// [R13] NMI, unmasked interrupt or reset wake stop
// [R14] Stop wake waits oscillator settling interval
// [R15] Settling timed by watchdog counter
// [R16] After settling, clock restarts then vector
// [R17] Idle bit self-clears when light mode ends
// [R18] Stop bit self-clears when stop ends
// [R19] Three-bit select picks settle count
// [R20] Gates open glitch-free after settling only
`timescale 1ns/10ps
module ipc_power_save (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sub_clk,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic nmi_req,
  input wire logic irq_req,
  input wire logic bus_hold_request,
  input wire logic cpu_on_sub_clk,
  output logic bus_hold_ack,
  output logic cpu_clk,
  output logic periph_clk,
  output logic sub_clk_out,
  output logic main_osc_en,
  output logic cpu_halted,
  output logic wake_vector_req
);
  typedef struct packed {
    ipc_pkg::ipc_state_type mode;
    logic idle_bit;
    logic deep_stop_request_bit;
    logic [2:0] osc_settle_select;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic vec;
    // Helper for the settle length check
    logic [ipc_pkg::CNT_W-1:0] settle_span;
  } ipc_top_state_type;

  ipc_top_state_type st;
  ipc_top_state_type next_st;
  logic wake;
  logic settle_start;
  logic settle_done;
  logic settle_busy;
  logic clk_open;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [ipc_pkg::CNT_W-1:0] span_goal;

  assign wake = nmi_req | irq_req; // [R8] [R13]
  // Word transfers only; other sizes are treated as idle
  assign addr_ok = hsel & hready & htrans == ipc_pkg::HTRANS_NONSEQ & hsize == 3'h2;

  always_comb begin
    case (haddr)
      ipc_pkg::OFS_PSC: rd_mux = {30'h0, st.idle_bit, st.deep_stop_request_bit};
      ipc_pkg::OFS_OSC_SETTLE_SELECT: rd_mux = {29'h0, st.osc_settle_select};
      ipc_pkg::OFS_STATUS: rd_mux = {28'h0, st.mode};
      default: rd_mux = 32'h0000_0000;
    endcase
    // A write in its data phase has not reached the register yet; pass it on
    if (st.wr_pend && st.wr_addr == haddr) begin
      if (haddr == ipc_pkg::OFS_PSC) begin
        rd_mux[ipc_pkg::PSC_IDLE_POS] = hwdata[ipc_pkg::PSC_IDLE_POS];
        rd_mux[ipc_pkg::PSC_STP_POS] = hwdata[ipc_pkg::PSC_STP_POS] & ~cpu_on_sub_clk;
      end else if (haddr == ipc_pkg::OFS_OSC_SETTLE_SELECT) begin
        rd_mux[2:0] = hwdata[2:0];
      end
    end
  end

  // Settle length expected from the select, decoded apart from the counter
  always_comb begin
    case (st.osc_settle_select)
      3'h0: span_goal = ipc_pkg::SETTLE_0;
      3'h1: span_goal = ipc_pkg::SETTLE_1;
      3'h2: span_goal = ipc_pkg::SETTLE_2;
      3'h3: span_goal = ipc_pkg::SETTLE_3;
      default: span_goal = ipc_pkg::SETTLE_4;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.vec = 1'b0;
    settle_start = 1'b0;
    next_st.wr_pend = addr_ok & hwrite;
    // Counts cycles spent settling; only the length check reads it
    if (st.mode == ipc_pkg::ST_SETTLE) begin
      next_st.settle_span = st.settle_span + 20'h00001;
    end else begin
      next_st.settle_span = 20'h00000;
    end
    if (addr_ok) begin
      next_st.wr_addr = haddr;
      next_st.rdata = rd_mux;
    end
    if (st.wr_pend) begin
      case (st.wr_addr)
        ipc_pkg::OFS_PSC: begin
          next_st.idle_bit = hwdata[ipc_pkg::PSC_IDLE_POS]; // [R1]
          // Stop on sub clock is refused here: the stop bit is masked with cpu_on_sub_clk
          next_st.deep_stop_request_bit = hwdata[ipc_pkg::PSC_STP_POS] & ~cpu_on_sub_clk; // [R9] [R11]
        end
        ipc_pkg::OFS_OSC_SETTLE_SELECT: next_st.osc_settle_select = hwdata[2:0]; // [R19]
        default: next_st.osc_settle_select = st.osc_settle_select;
      endcase
    end
    case (st.mode)
      ipc_pkg::ST_RUN: begin
        if (st.deep_stop_request_bit) begin
          next_st.mode = ipc_pkg::ST_STOP; // [R9]
        end else if (st.idle_bit) begin
          next_st.mode = ipc_pkg::ST_IDLE; // [R1]
        end
      end
      ipc_pkg::ST_IDLE: begin
        if (wake) begin
          next_st.mode = ipc_pkg::ST_RUN; // [R4] [R8]
          next_st.idle_bit = 1'b0; // [R17]
          next_st.vec = 1'b1;
        end
      end
      ipc_pkg::ST_STOP: begin
        if (wake) begin
          next_st.mode = ipc_pkg::ST_SETTLE; // [R14]
          settle_start = 1'b1; // [R15]
        end
      end
      ipc_pkg::ST_SETTLE: begin
        if (settle_done) begin
          next_st.mode = ipc_pkg::ST_RUN; // [R16]
          next_st.deep_stop_request_bit = 1'b0; // [R18]
          next_st.vec = 1'b1; // [R16]
        end
      end
      default: next_st.mode = ipc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.mode <= ipc_pkg::ST_RUN;
      st.idle_bit <= 1'b0;
      st.deep_stop_request_bit <= 1'b0;
      st.osc_settle_select <= ipc_pkg::OSC_SETTLE_SELECT_RESET;
      st.wr_pend <= 1'b0;
      st.wr_addr <= 32'h0000_0000;
      st.rdata <= 32'h0000_0000;
      st.vec <= 1'b0;
      st.settle_span <= 20'h00000;
    end else begin
      st <= next_st;
    end
  end

  ipc_settle_counter u_settle (
    .clk(clk),
    .rst_b(rst_b),
    .start(settle_start),
    .osc_settle_select(st.osc_settle_select),
    .done(settle_done),
    .busy(settle_busy)
  );

  // Gates closed in idle, stop and settle; registers hold because clocks stop
  assign clk_open = st.mode == ipc_pkg::ST_RUN; // [R2] [R5] [R6] [R12] [R20]

  ipc_clock_gate u_cpu_gate (
    .clk(clk),
    .rst_b(rst_b),
    .enable(clk_open),
    .gclk(cpu_clk)
  );

  ipc_clock_gate u_per_gate (
    .clk(clk),
    .rst_b(rst_b),
    .enable(clk_open),
    .gclk(periph_clk)
  );

  assign sub_clk_out = sub_clk; // [R3] [R10]
  // Oscillator model: clk stays as reference so the counter can run
  assign main_osc_en = ~(st.mode == ipc_pkg::ST_STOP); // [R10]
  assign cpu_halted = ~clk_open; // [R5] [R12]
  assign bus_hold_ack = bus_hold_request & (st.mode == ipc_pkg::ST_RUN); // [R7]
  assign wake_vector_req = st.vec; // [R16]
  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  sequence stop_wake_s;
    st.mode == ipc_pkg::ST_STOP && wake;
  endsequence

  sequence settle_end_s;
    st.mode == ipc_pkg::ST_SETTLE && settle_done;
  endsequence

  idle_no_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_IDLE |-> !bus_hold_ack) // [R7]
    else $error("bus hold granted in idle");
  idle_wake_fast_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_IDLE && wake |=> st.mode == ipc_pkg::ST_RUN && wake_vector_req) // [R4]
    else $error("idle wake not immediate");
  idle_bit_clr_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_IDLE && wake |=> !st.idle_bit) // [R17]
    else $error("idle bit not cleared");
  stop_settle_a: assert property (@(posedge clk) disable iff (!rst_b)
    stop_wake_s |=> st.mode == ipc_pkg::ST_SETTLE [*8]) // [R14]
    else $error("settle wait skipped");
  gate_closed_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_SETTLE && !settle_done
    |=> st.mode == ipc_pkg::ST_SETTLE && !clk_open && cpu_halted) // [R20]
    else $error("gate open during settle");
  stop_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_RUN && st.deep_stop_request_bit |=> !main_osc_en) // [R9]
    else $error("stop not entered");
  stop_bit_clr_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_SETTLE && settle_done |=> !st.deep_stop_request_bit && wake_vector_req) // [R18]
    else $error("stop bit not cleared");
  idle_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_RUN && st.idle_bit && !st.deep_stop_request_bit
    |=> st.mode == ipc_pkg::ST_IDLE) // [R1]
    else $error("idle not entered");

  // Stop wake, settling and return to run
  stop_wake_go_a: assert property (@(posedge clk) disable iff (!rst_b)
    stop_wake_s |=> st.mode == ipc_pkg::ST_SETTLE && settle_busy) // [R13]
    else $error("stop wake did not start settling");
  stop_osc_on_a: assert property (@(posedge clk) disable iff (!rst_b)
    stop_wake_s |=> main_osc_en) // [R14]
    else $error("oscillator off while settling");
  settle_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_SETTLE |-> settle_busy || settle_done) // [R15]
    else $error("settle without running count");
  settle_span_a: assert property (@(posedge clk) disable iff (!rst_b)
    settle_end_s |-> st.settle_span == span_goal) // [R14]
    else $error("settle length differs from select");
  settle_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
    settle_end_s |=> st.mode == ipc_pkg::ST_RUN && main_osc_en && !cpu_halted) // [R16] [R20]
    else $error("clock not restarted after settle");
  stop_stay_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_STOP && !wake |=> st.mode == ipc_pkg::ST_STOP && cpu_halted) // [R12]
    else $error("stop left without wake");
  stop_osc_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_STOP |-> !main_osc_en && !bus_hold_ack) // [R10]
    else $error("oscillator or hold active in stop");

  // Idle stays put until a wake
  idle_stay_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_IDLE && !wake |=> st.mode == ipc_pkg::ST_IDLE && cpu_halted) // [R5]
    else $error("idle left without wake");
  idle_osc_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == ipc_pkg::ST_IDLE |-> main_osc_en && cpu_halted) // [R2]
    else $error("oscillator stopped in idle");

  // Wake vector pulse
  vec_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    wake_vector_req |=> !wake_vector_req) // [R16]
    else $error("vector request longer than a cycle");
  vec_source_a: assert property (@(posedge clk) disable iff (!rst_b)
    wake_vector_req |-> st.mode == ipc_pkg::ST_RUN
    && ($past(st.mode) == ipc_pkg::ST_IDLE || $past(st.mode) == ipc_pkg::ST_SETTLE)) // [R16]
    else $error("vector request without wake");

  // Bus side: hold grant and register writes
  hold_grant_a: assert property (@(posedge clk) disable iff (!rst_b)
    bus_hold_request && st.mode == ipc_pkg::ST_RUN |-> bus_hold_ack) // [R7]
    else $error("bus hold not granted in run");
  osc_settle_select_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.wr_pend && st.wr_addr == ipc_pkg::OFS_OSC_SETTLE_SELECT
    |=> st.osc_settle_select == $past(hwdata[2:0])) // [R19]
    else $error("settle select not written");
  idle_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.wr_pend && st.wr_addr == ipc_pkg::OFS_PSC && st.mode == ipc_pkg::ST_RUN
    |=> st.idle_bit == $past(hwdata[ipc_pkg::PSC_IDLE_POS])) // [R1]
    else $error("idle bit not written");
  stop_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.wr_pend && st.wr_addr == ipc_pkg::OFS_PSC && cpu_on_sub_clk
    |=> !st.deep_stop_request_bit) // [R11]
    else $error("stop taken on sub clock");
endmodule : ipc_power_save

// ==== verif/ipc_wake_model.sv ====
// Wake sources and sub clock seen from the far side of the sequencer
`timescale 1ns/10ps
module ipc_wake_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fire_irq,
  input wire logic fire_nmi,
  input wire logic wake_vector_req,
  output logic nmi_req,
  output logic irq_req,
  output logic sub_clk
);
  // Free-running watch crystal, unrelated in phase to clk
  initial begin
    sub_clk = 1'b0;
    forever #15259 sub_clk = ~sub_clk;
  end
  // Level request held until the handler is entered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_req <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      nmi_req <= fire_nmi | (nmi_req & ~wake_vector_req);
      irq_req <= fire_irq | (irq_req & ~wake_vector_req);
    end
  end
endmodule : ipc_wake_model

// ==== verif/ipc_power_save_bench.sv ====
// Self-checking bench for the power-save sequencer
`timescale 1ns/10ps
module ipc_power_save_bench;
  logic clk, rst_b, sub_clk, hsel, hwrite, hready, nmi_req, irq_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, hold_req, on_sub, hold_ack, cpu_clk, periph_clk;
  logic sub_clk_out, main_osc_en, cpu_halted, vec, fire_irq, fire_nmi, halted_q;
  int mismatches = 0, total_checks = 0, cycles = 0, leaks = 0, n;

  ipc_power_save u_ipc_power_save (.clk(clk), .rst_b(rst_b), .sub_clk(sub_clk), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .nmi_req(nmi_req), .irq_req(irq_req), .bus_hold_request(hold_req),
    .cpu_on_sub_clk(on_sub), .bus_hold_ack(hold_ack), .cpu_clk(cpu_clk),
    .periph_clk(periph_clk), .sub_clk_out(sub_clk_out), .main_osc_en(main_osc_en),
    .cpu_halted(cpu_halted), .wake_vector_req(vec));
  ipc_wake_model u_ipc_wake_model (.clk(clk), .rst_b(rst_b), .fire_irq(fire_irq),
    .fire_nmi(fire_nmi), .wake_vector_req(vec), .nmi_req(nmi_req), .irq_req(irq_req),
    .sub_clk(sub_clk));
  assign hready = hreadyout;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Gated clock must not pulse once halted for a whole cycle
  always @(posedge clk) begin
    #1;
    if (halted_q && cpu_halted === 1'b1 && (cpu_clk !== 1'b0 || periph_clk !== 1'b0)) leaks++;
    halted_q = (cpu_halted === 1'b1);
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ipc_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  task automatic wait_vec;
    n = 0;
    // Sample at the falling edge, away from the edge that launches the pulse
    do begin
      @(negedge clk);
      n++;
    end while (vec !== 1'b1);
    @(posedge clk);
  endtask : wait_vec

  initial begin
    rst_b = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; hold_req = 1'b0; on_sub = 1'b0; fire_irq = 1'b0; fire_nmi = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_chk(ipc_pkg::OFS_PSC, 32'h0);
    rd_chk(ipc_pkg::OFS_OSC_SETTLE_SELECT, 32'h4);
    rd_chk(ipc_pkg::OFS_STATUS, 32'h1);
    rd_chk(32'h0000_000c, 32'h0);
    $display("reset test done");
    hold_req <= 1'b1;
    @(posedge clk);
    chk(hold_ack, 1'b1);
    bus(ipc_pkg::OFS_PSC, 1'b1, 32'h2);
    repeat (2) @(posedge clk);
    chk(cpu_halted, 1'b1);
    chk(hold_ack, 1'b0);
    chk(main_osc_en, 1'b1);
    chk(sub_clk_out, sub_clk);
    rd_chk(ipc_pkg::OFS_STATUS, 32'h2);
    fire_irq <= 1'b1;
    @(posedge clk);
    fire_irq <= 1'b0;
    wait_vec();
    chk(32'(n <= 4), 32'h1);
    rd_chk(ipc_pkg::OFS_PSC, 32'h0);
    $display("idle test done");
    hold_req <= 1'b0;
    bus(ipc_pkg::OFS_OSC_SETTLE_SELECT, 1'b1, 32'h0);
    rd_chk(ipc_pkg::OFS_OSC_SETTLE_SELECT, 32'h0);
    bus(ipc_pkg::OFS_PSC, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    chk(main_osc_en, 1'b0);
    chk(cpu_halted, 1'b1);
    chk(sub_clk_out, sub_clk);
    fire_nmi <= 1'b1;
    @(posedge clk);
    fire_nmi <= 1'b0;
    wait_vec();
    chk(32'(n >= 16384 && n <= 16392), 32'h1);
    rd_chk(ipc_pkg::OFS_PSC, 32'h0);
    chk(leaks, 32'h0);
    $display("stop test done");
    // Stop request while on the sub clock must be dropped
    on_sub <= 1'b1;
    bus(ipc_pkg::OFS_PSC, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    rd_chk(ipc_pkg::OFS_STATUS, 32'h1);
    on_sub <= 1'b0;
    $display("refusal test done");
    test_done();
  end
endmodule : ipc_power_save_bench
